// ==== rtl/spr_pkg.sv ====
// Shared constants for the stack, pull, push and rotate execution block
package spr_pkg;
  // Opcode bytes
  localparam logic [7:0] OP_PREFIX = 8'h18;
  localparam logic [7:0] OP_PUSH_IDX = 8'h3C;
  localparam logic [7:0] OP_PULL_A = 8'h32;
  localparam logic [7:0] OP_PULL_B = 8'h33;
  localparam logic [7:0] OP_PULL_IDX = 8'h38;
  localparam logic [7:0] OP_ROL_A = 8'h49;
  localparam logic [7:0] OP_ROL_B = 8'h59;
  localparam logic [7:0] OP_ROL_EXT = 8'h79;
  localparam logic [7:0] OP_ROL_IDX = 8'h69;
  localparam logic [7:0] OP_ROR_A = 8'h46;
  localparam logic [7:0] OP_ROR_B = 8'h56;
  localparam logic [7:0] OP_ROR_EXT = 8'h76;
  localparam logic [7:0] OP_ROR_IDX = 8'h66;
  // Address driven during internal dead cycles
  localparam logic [15:0] DEAD_ADDR = 16'hFFFF;
  // Condition flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  // Reset values
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h00FF;
  localparam logic [7:0] RST_FLAGS = 8'hD0;
  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_SP = 8'h0C;
  localparam logic [7:0] REG_X = 8'h10;
  localparam logic [7:0] REG_Y = 8'h14;
  localparam logic [7:0] REG_AB = 8'h18;
  localparam logic [7:0] REG_FLAGS = 8'h1C;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    ST_FETCH = 4'b0000,
    ST_FETCH2 = 4'b0001,
    ST_DUMMY = 4'b0010,
    ST_HH = 4'b0011,
    ST_LL = 4'b0100,
    ST_OFF = 4'b0101,
    ST_IDXD = 4'b0110,
    ST_READ = 4'b0111,
    ST_RMWD = 4'b1000,
    ST_WRITE = 4'b1001,
    ST_PUSHL = 4'b1010,
    ST_PUSHH = 4'b1011,
    ST_SPDUM = 4'b1100,
    ST_PULLH = 4'b1101,
    ST_PULLL = 4'b1110
  } spr_state_type;
endpackage

// ==== rtl/spr_rotate.sv ====
// Eight-bit rotate through carry with flag results
`timescale 1ns/1ps
module spr_rotate (
  input wire logic [7:0] din, // Operand
  input wire logic cin, // Old carry
  input wire logic left, // 1 rotate left, 0 rotate right
  output logic [7:0] dout, // Result
  output logic n, // Negative
  output logic z, // Zero
  output logic v, // N xor C after rotate
  output logic c // New carry
);
  assign dout = left ? {din[6:0], cin} : {cin, din[7:1]}; // [RQ6] [RQ10]
  assign c = left ? din[7] : din[0]; // [RQ6] [RQ10]
  assign n = dout[7]; // [RQ7]
  assign z = (dout == 8'h00); // [RQ7]
  assign v = n ^ c; // [RQ7]
endmodule

// ==== rtl/spr_exec.sv ====
// Execution core for push, pull and rotate-through-carry instructions
//
// Overview of operation
// [RQ1] Prefix then push code pushes second index, low byte first.
// [RQ2] Push second index: five cycles, dummy fetch, writes at SP, SP-1.
// [RQ3] Pull A or B: four cycles, dummy read at SP, load from SP+1.
// [RQ4] Pull first index: five cycles, high at SP+1, low at SP+2.
// [RQ5] Pull second index: six cycles, prefix, opcode, dummy, then pulls.
// [RQ6] Rotate left: bit 0 from old carry, carry from old bit 7.
// [RQ7] Rotate flags: N from bit 7, Z on zero, V is N xor C.
// [RQ8] Rotate-left decode: A, B, extended, first and second index.
// [RQ9] Memory rotate: read, dead cycle at FFFF, then write result.
// [RQ10] Rotate right: bit 7 from old carry, carry from old bit 0.
// [RQ11] Rotate-right decode and bus cycles mirror rotate left.
// [RQ12] Push and pull keep flags; SP arithmetic wraps at 16 bits.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module spr_exec (
  input wire logic aclk, // 50 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  // CPU bus towards memory, one bus cycle per clock
  output logic [15:0] cpu_addr, // Bus address
  output logic cpu_rw, // 1 read, 0 write
  output logic [7:0] cpu_dout, // Write data
  input wire logic [7:0] cpu_din, // Read data for the current cycle
  // AXI4-Lite register port
  input wire logic [7:0] s_awaddr, // Write address
  input wire logic s_awvalid, // Write address valid
  output logic s_awready, // Write address ready
  input wire logic [31:0] s_wdata, // Write data
  input wire logic [3:0] s_wstrb, // Write strobes
  input wire logic s_wvalid, // Write data valid
  output logic s_wready, // Write data ready
  output logic [1:0] s_bresp, // Write response
  output logic s_bvalid, // Write response valid
  input wire logic s_bready, // Write response ready
  input wire logic [7:0] s_araddr, // Read address
  input wire logic s_arvalid, // Read address valid
  output logic s_arready, // Read address ready
  output logic [31:0] s_rdata, // Read data
  output logic [1:0] s_rresp, // Read response
  output logic s_rvalid, // Read data valid
  input wire logic s_rready // Read data ready
);
  import spr_pkg::*;

  spr_state_type st_q, st_d;
  logic [15:0] addr_q, addr_d, pc_q, pc_d, sp_q, sp_d;
  logic [15:0] x_q, x_d, y_q, y_d, ea_q, ea_d;
  logic [7:0] a_q, a_d, b_q, b_d, ccr_q, ccr_d, wdata_q, wdata_d;
  logic [7:0] op_q, op_d;
  logic rw_q, rw_d, pre_q, pre_d, run_q, run_d;
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Instruction classification
  wire cur_pre = (st_q == ST_FETCH2);
  wire dec_ext = !cur_pre && (cpu_din == OP_ROL_EXT || cpu_din == OP_ROR_EXT);
  wire dec_idx = (cpu_din == OP_ROL_IDX || cpu_din == OP_ROR_IDX);
  wire is_push = pre_q && op_q == OP_PUSH_IDX; // [RQ1]
  wire is_pull_acc = !pre_q && (op_q == OP_PULL_A || op_q == OP_PULL_B);
  wire is_pull_idx = op_q == OP_PULL_IDX;
  wire is_rot_acc = !pre_q && (op_q == OP_ROL_A || op_q == OP_ROL_B ||
                    op_q == OP_ROR_A || op_q == OP_ROR_B); // [RQ8] [RQ11]
  wire halted = (st_q == ST_FETCH) && !run_q;
  wire [15:0] idx_base = pre_q ? y_q : x_q;
  wire [15:0] sp_inc = sp_q + 16'h0001; // [RQ12]
  wire [15:0] sp_dec = sp_q - 16'h0001; // [RQ12]
  wire [15:0] pc_inc = pc_q + 16'h0001;

  // Rotate source: held accumulator, or memory byte in the read cycle
  wire [7:0] rot_in = (st_q == ST_READ) ? cpu_din : (op_q[4] ? b_q : a_q);
  wire [7:0] rot_out;
  wire rot_n, rot_z, rot_v, rot_c;
  wire [7:0] rot_flags = {ccr_q[7:4], rot_n, rot_z, rot_v, rot_c};
  spr_rotate u_rot (
    .din(rot_in),
    .cin(ccr_q[FLAG_C]),
    .left(op_q[3]),
    .dout(rot_out),
    .n(rot_n),
    .z(rot_z),
    .v(rot_v),
    .c(rot_c)
  );

  // AXI handshake terms
  wire wr_go = s_awvalid && s_wvalid && !awready_q && !bvalid_q;
  wire wr_fire = awready_q && s_awvalid && s_wvalid;
  wire rd_go = s_arvalid && !arready_q && !rvalid_q;
  wire rd_fire = arready_q && s_arvalid;
  wire wr_known = s_awaddr[7:5] == 3'b000 && s_awaddr[1:0] == 2'b00 &&
                  s_awaddr != REG_STATUS;
  wire rd_known = s_araddr[7:5] == 3'b000 && s_araddr[1:0] == 2'b00;
  // CPU registers only take software writes while the core is halted,
  // so the sequencer never fights the bus over the same flop
  wire cpu_wr = wr_fire && halted;
  logic [31:0] rd_mux;

  always_comb begin
    unique case (s_araddr)
      REG_CTRL: rd_mux = {31'h0, run_q};
      REG_STATUS: rd_mux = {11'h0, pre_q, st_q, op_q, 7'h0, halted};
      REG_PC: rd_mux = {16'h0, pc_q};
      REG_SP: rd_mux = {16'h0, sp_q};
      REG_X: rd_mux = {16'h0, x_q};
      REG_Y: rd_mux = {16'h0, y_q};
      REG_AB: rd_mux = {16'h0, b_q, a_q};
      REG_FLAGS: rd_mux = {24'h0, ccr_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    rw_d = 1'b1;
    wdata_d = wdata_q;
    pc_d = pc_q;
    sp_d = sp_q;
    x_d = x_q;
    y_d = y_q;
    a_d = a_q;
    b_d = b_q;
    ccr_d = ccr_q;
    ea_d = ea_q;
    op_d = op_q;
    pre_d = pre_q;
    run_d = run_q;
    if (wr_fire && s_awaddr == REG_CTRL && s_wstrb[0]) begin
      run_d = s_wdata[CTRL_RUN_BIT];
    end
    if (cpu_wr) begin
      unique case (s_awaddr)
        REG_PC: pc_d = merge16(pc_q, s_wdata, s_wstrb);
        REG_SP: sp_d = merge16(sp_q, s_wdata, s_wstrb);
        REG_X: x_d = merge16(x_q, s_wdata, s_wstrb);
        REG_Y: y_d = merge16(y_q, s_wdata, s_wstrb);
        REG_AB: {b_d, a_d} = merge16({b_q, a_q}, s_wdata, s_wstrb);
        REG_FLAGS: ccr_d = s_wstrb[0] ? s_wdata[7:0] : ccr_q;
        default: ccr_d = ccr_q;
      endcase
    end
    unique case (st_q)
      ST_FETCH, ST_FETCH2: begin
        if (!halted) begin
          op_d = cpu_din;
          pc_d = pc_inc;
          addr_d = pc_inc;
          if (!cur_pre && cpu_din == OP_PREFIX) begin
            pre_d = 1'b1;
            st_d = ST_FETCH2; // [RQ1] [RQ5]
          end else begin
            pre_d = cur_pre;
            st_d = dec_ext ? ST_HH : (dec_idx ? ST_OFF : ST_DUMMY); // [RQ8]
          end
        end else begin
          addr_d = pc_d;
        end
      end
      ST_DUMMY: begin
        addr_d = pc_q;
        st_d = ST_FETCH;
        if (is_push) begin
          addr_d = sp_q;
          rw_d = 1'b0;
          wdata_d = y_q[7:0]; // [RQ1]
          st_d = ST_PUSHL;
        end else if (is_pull_acc || is_pull_idx) begin
          addr_d = sp_q; // [RQ3] [RQ4] [RQ5]
          st_d = ST_SPDUM;
        end else if (is_rot_acc) begin
          if (op_q[4]) begin
            b_d = rot_out;
          end else begin
            a_d = rot_out;
          end
          ccr_d = rot_flags; // [RQ7]
        end
      end
      ST_PUSHL: begin
        sp_d = sp_dec;
        addr_d = sp_dec;
        rw_d = 1'b0;
        wdata_d = y_q[15:8]; // [RQ2]
        st_d = ST_PUSHH;
      end
      ST_PUSHH: begin
        sp_d = sp_dec; // [RQ2]
        addr_d = pc_q;
        st_d = ST_FETCH;
      end
      ST_SPDUM: begin
        sp_d = sp_inc;
        addr_d = sp_inc;
        st_d = ST_PULLH;
      end
      ST_PULLH: begin
        addr_d = pc_q;
        st_d = ST_FETCH;
        if (op_q == OP_PULL_A) begin
          a_d = cpu_din; // [RQ3]
        end else if (op_q == OP_PULL_B) begin
          b_d = cpu_din; // [RQ3]
        end else begin
          if (pre_q) begin
            y_d[15:8] = cpu_din; // [RQ5]
          end else begin
            x_d[15:8] = cpu_din; // [RQ4]
          end
          sp_d = sp_inc;
          addr_d = sp_inc;
          st_d = ST_PULLL;
        end
      end
      ST_PULLL: begin
        if (pre_q) begin
          y_d[7:0] = cpu_din; // [RQ5]
        end else begin
          x_d[7:0] = cpu_din; // [RQ4]
        end
        addr_d = pc_q;
        st_d = ST_FETCH;
      end
      ST_HH: begin
        ea_d[15:8] = cpu_din;
        pc_d = pc_inc;
        addr_d = pc_inc;
        st_d = ST_LL;
      end
      ST_LL: begin
        ea_d = {ea_q[15:8], cpu_din};
        pc_d = pc_inc;
        addr_d = {ea_q[15:8], cpu_din};
        st_d = ST_READ;
      end
      ST_OFF: begin
        ea_d = idx_base + {8'h00, cpu_din}; // Offset is unsigned
        pc_d = pc_inc;
        addr_d = DEAD_ADDR; // [RQ9]
        st_d = ST_IDXD;
      end
      ST_IDXD: begin
        addr_d = ea_q;
        st_d = ST_READ;
      end
      ST_READ: begin
        // Flags settle here; the result waits in the write-data flop
        wdata_d = rot_out; // [RQ6] [RQ10]
        ccr_d = rot_flags; // [RQ7]
        addr_d = DEAD_ADDR; // [RQ9]
        st_d = ST_RMWD;
      end
      ST_RMWD: begin
        addr_d = ea_q;
        rw_d = 1'b0; // [RQ9]
        st_d = ST_WRITE;
      end
      ST_WRITE: begin
        addr_d = pc_q;
        st_d = ST_FETCH;
      end
      default: begin
        addr_d = pc_q;
        st_d = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_FETCH;
      addr_q <= RST_PC;
      rw_q <= 1'b1;
      wdata_q <= 8'h00;
      pc_q <= RST_PC;
      sp_q <= RST_SP;
      x_q <= 16'h0000;
      y_q <= 16'h0000;
      a_q <= 8'h00;
      b_q <= 8'h00;
      ccr_q <= RST_FLAGS;
      ea_q <= 16'h0000;
      op_q <= 8'h00;
      pre_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      wdata_q <= wdata_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      x_q <= x_d;
      y_q <= y_d;
      a_q <= a_d;
      b_q <= b_d;
      ccr_q <= ccr_d;
      ea_q <= ea_d;
      op_q <= op_d;
      pre_q <= pre_d;
      run_q <= run_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      awready_q <= wr_go;
      arready_q <= rd_go;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign cpu_addr = addr_q;
  assign cpu_rw = rw_q;
  assign cpu_dout = wdata_q;
  assign s_awready = awready_q;
  assign s_wready = awready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_push_low_byte: assert property ( // [RQ1]
    st_q == ST_PUSHL |-> !rw_q && addr_q == sp_q && wdata_q == y_q[7:0])
    else $error("push low byte not written at stack pointer");
  a_push_high_sp: assert property ( // [RQ2]
    st_q == ST_PUSHL |=> !rw_q && addr_q == $past(sp_q) - 16'h0001 &&
      wdata_q == y_q[15:8] ##1 sp_q == $past(sp_q, 2) - 16'h0002)
    else $error("push high byte or stack pointer wrong");
  a_pull_acc_seq: assert property ( // [RQ3]
    st_q == ST_DUMMY && is_pull_acc |=> st_q == ST_SPDUM && rw_q
      ##1 st_q == ST_PULLH && addr_q == sp_q ##1 st_q == ST_FETCH)
    else $error("accumulator pull sequence wrong");
  a_pull_addr_step: assert property ( // [RQ4]
    st_q == ST_SPDUM |=> addr_q == $past(addr_q) + 16'h0001 && rw_q)
    else $error("pull address does not step from stack pointer");
  a_pull_y_len: assert property ( // [RQ5]
    st_q == ST_FETCH2 && cpu_din == OP_PULL_IDX |=> st_q == ST_DUMMY
      ##1 st_q == ST_SPDUM ##1 st_q == ST_PULLH ##1 st_q == ST_PULLL
      ##1 st_q == ST_FETCH && sp_q == $past(sp_q, 4) + 16'h0002)
    else $error("second index pull length or stack pointer wrong");
  a_rol_acc_a: assert property ( // [RQ6]
    st_q == ST_DUMMY && !pre_q && op_q == OP_ROL_A |=>
      a_q == {$past(a_q[6:0]), $past(ccr_q[FLAG_C])} &&
      ccr_q[FLAG_C] == $past(a_q[7]))
    else $error("rotate left of accumulator wrong");
  a_rot_flags: assert property ( // [RQ7]
    st_q == ST_READ |=> ccr_q[FLAG_V] == (ccr_q[FLAG_N] ^ ccr_q[FLAG_C]) &&
      ccr_q[FLAG_N] == wdata_q[7] && ccr_q[FLAG_Z] == (wdata_q == 8'h00))
    else $error("rotate flags wrong");
  a_rot_acc_len: assert property ( // [RQ8]
    st_q == ST_FETCH && run_q && (cpu_din == OP_ROL_A ||
      cpu_din == OP_ROL_B) |=> st_q == ST_DUMMY ##1 st_q == ST_FETCH)
    else $error("accumulator rotate not two cycles");
  a_rmw_dead: assert property ( // [RQ9]
    st_q == ST_READ |=> addr_q == DEAD_ADDR && rw_q
      ##1 !rw_q && addr_q == ea_q ##1 rw_q)
    else $error("read-modify-write dead cycle or write wrong");
  a_ror_mem: assert property ( // [RQ10]
    st_q == ST_READ && !op_q[3] |=> wdata_q[7] == $past(ccr_q[FLAG_C]) &&
      ccr_q[FLAG_C] == $past(cpu_din[0]))
    else $error("rotate right of memory wrong");
  a_ror_ext_seq: assert property ( // [RQ11]
    st_q == ST_HH && op_q == OP_ROR_EXT |=> st_q == ST_LL ##1
      st_q == ST_READ ##1 st_q == ST_RMWD ##1 st_q == ST_WRITE)
    else $error("extended rotate right sequence wrong");
  a_pull_flags_kept: assert property ( // [RQ12]
    st_q inside {ST_SPDUM, ST_PULLH, ST_PULLL, ST_PUSHL, ST_PUSHH}
      |=> ccr_q == $past(ccr_q))
    else $error("push or pull changed condition flags");

  c_push_y: cover property (st_q == ST_PUSHH);
  c_pull_y: cover property (st_q == ST_PULLL && pre_q);
  c_rol_ext: cover property (st_q == ST_WRITE && op_q == OP_ROL_EXT);
  c_ror_idx_y: cover property (st_q == ST_WRITE && pre_q && !op_q[3]);
endmodule

// ==== test/spr_mem_model.sv ====
// Byte memory that answers the core's bus within the same cycle
`timescale 1ns/1ps
module spr_mem_model (
  input wire logic aclk, // Bus clock
  input wire logic [15:0] cpu_addr, // Address of this bus cycle
  input wire logic cpu_rw, // 1 read, 0 write
  input wire logic [7:0] cpu_dout, // Write data from the core
  output logic [7:0] cpu_din // Read data
);
  logic [7:0] mem [0:65535];
  // Plain always: the bench preloads this array by hierarchical writes
  always @(posedge aclk) begin
    if (!cpu_rw) begin
      mem[cpu_addr] <= cpu_dout;
    end
  end
  // Nobody drives the data lines on a write, so show junk, not old data
  assign cpu_din = cpu_rw ? mem[cpu_addr] : ~cpu_dout;
endmodule

// ==== test/stack_pull_push_rotate_exec_test.sv ====
// Self-checking bench for the push, pull and rotate core
`timescale 1ns/1ps
module stack_pull_push_rotate_exec_test;
  import spr_pkg::*;
  logic aclk, aresetn, cpu_rw, rec;
  logic [15:0] cpu_addr, pc, sp, xr, yr;
  logic [7:0] cpu_dout, cpu_din, s_awaddr, s_araddr, ra, rb, fl;
  logic [31:0] s_wdata, s_rdata, seed, d;
  logic [3:0] s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp, r;
  logic [7:0] rm [0:65535];
  logic [24:0] eq[$], tr[$];
  int bad_count, checked, cyc, i, k;

  spr_exec u_spr_exec (.aclk(aclk), .aresetn(aresetn),
    .cpu_addr(cpu_addr), .cpu_rw(cpu_rw), .cpu_dout(cpu_dout),
    .cpu_din(cpu_din), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  spr_mem_model u_spr_mem_model (.aclk(aclk), .cpu_addr(cpu_addr),
    .cpu_rw(cpu_rw), .cpu_dout(cpu_dout), .cpu_din(cpu_din));

  always #10 aclk = ~aclk;

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rec) tr.push_back({cpu_addr, cpu_rw, cpu_rw ? 8'h00 : cpu_dout});
    if (cyc == 4000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cyc(input logic [24:0] got, input logic [24:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t bus got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    @(posedge aclk);
    // Each channel is released on its own ready
    while (s_awvalid || s_wvalid) begin
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
      @(posedge aclk);
    end
    while (s_bvalid !== 1'b1) @(posedge aclk);
    r = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    @(posedge aclk);
    while (s_arready !== 1'b1) @(posedge aclk);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge aclk);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic chk(input logic [7:0] a, input logic [15:0] e,
                     input logic [1:0] er);
    axi_rd(a);
    cmp_val({14'h0, r, d[15:0]}, {14'h0, er, e});
  endtask

  task automatic emit(input logic [15:0] a, input logic [7:0] v);
    rm[a] = v;
    u_spr_mem_model.mem[a] = v;
  endtask

  task automatic rd(input logic [15:0] a);
    eq.push_back({a, 1'b1, 8'h00});
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    eq.push_back({a, 1'b0, v});
    rm[a] = v;
  endtask

  task automatic f(input logic [7:0] v);
    emit(pc, v);
    rd(pc);
    pc = pc + 16'h1;
  endtask

  task automatic rotv(inout logic [7:0] v, input logic left);
    logic c;
    c = left ? v[7] : v[0];
    v = left ? {v[6:0], fl[FLAG_C]} : {fl[FLAG_C], v[7:1]};
    fl[FLAG_C] = c;
    fl[FLAG_N] = v[7];
    fl[FLAG_Z] = (v == 8'h00);
    fl[FLAG_V] = v[7] ^ c;
  endtask

  task automatic i_push_idx();
    f(OP_PREFIX);
    f(OP_PUSH_IDX);
    rd(pc);
    wr(sp, yr[7:0]);
    wr(sp - 16'h1, yr[15:8]);
    sp = sp - 16'h2;
  endtask

  task automatic i_pull(input logic [7:0] op, input logic pre);
    if (pre) f(OP_PREFIX);
    f(op);
    rd(pc);
    rd(sp);
    sp = sp + 16'h1;
    rd(sp);
    if (op == OP_PULL_A) ra = rm[sp];
    else if (op == OP_PULL_B) rb = rm[sp];
    else begin
      sp = sp + 16'h1;
      rd(sp);
      if (pre) yr = {rm[sp - 16'h1], rm[sp]};
      else xr = {rm[sp - 16'h1], rm[sp]};
    end
  endtask

  task automatic i_inh(input logic [7:0] op);
    f(op);
    rd(pc);
    if (op[4]) rotv(rb, op[3]);
    else rotv(ra, op[3]);
  endtask

  // Memory forms: mode 0 extended at ext, 1 first index, 2 second index
  task automatic i_mem(input logic [7:0] op, input int mode,
                       input logic [15:0] ext);
    logic [7:0] v;
    logic [7:0] off;
    logic [15:0] ea;
    off = rnd();
    ea = ext;
    if (mode == 2) f(OP_PREFIX);
    f(op);
    if (mode == 0) begin
      f(ext[15:8]);
      f(ext[7:0]);
    end else begin
      f(off);
      rd(DEAD_ADDR);
      ea = (mode == 2 ? yr : xr) + {8'h00, off};
    end
    rd(ea);
    rd(DEAD_ADDR);
    v = rm[ea];
    rotv(v, op[3]);
    wr(ea, v);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    rec = 1'b0;
    seed = 32'h9024;
    {s_awaddr, s_araddr, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hF;
    {bad_count, checked, cyc} = '0;
    for (i = 0; i < 65536; i++) emit(i[15:0], 8'h01);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(REG_SP, RST_SP, RESP_OKAY);
    chk(REG_FLAGS, {8'h00, RST_FLAGS}, RESP_OKAY);
    chk(REG_PC, RST_PC, RESP_OKAY);
    chk(8'h20, 16'h0000, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h1);
    cmp_val({30'h0, r}, {30'h0, RESP_SLVERR});
    sp = 16'h0001;
    xr = {8'h00, rnd()};
    yr = {8'h04, rnd()};
    ra = rnd();
    rb = rnd();
    d = {24'h0, rnd()};
    fl = {4'hD, d[3:1], 1'b0};
    pc = 16'h0100;
    axi_wr(REG_SP, {16'h0, sp});
    axi_wr(REG_X, {16'h0, xr});
    axi_wr(REG_Y, {16'h0, yr});
    axi_wr(REG_AB, {16'h0, rb, ra});
    axi_wr(REG_FLAGS, {24'h0, fl});
    axi_wr(REG_PC, {16'h0, pc});
    // Stack bytes for the pulls; 80 with carry clear rotates to zero
    emit(16'h0002, 8'h80);
    emit(16'h0003, rnd());
    emit(16'h0004, 8'h03);
    emit(16'h0005, rnd());
    for (i = 16'h0300; i < 16'h0600; i++) emit(i[15:0], rnd());
    i_push_idx();
    i_pull(OP_PULL_IDX, 1'b1);
    i_pull(OP_PULL_A, 1'b0);
    i_pull(OP_PULL_B, 1'b0);
    i_pull(OP_PULL_IDX, 1'b0);
    i_inh(OP_ROL_A);
    i_inh(OP_ROL_B);
    i_inh(OP_ROR_A);
    i_inh(OP_ROR_B);
    i_mem(OP_ROL_EXT, 0, 16'h0500);
    i_mem(OP_ROR_EXT, 0, 16'h0501);
    i_mem(OP_ROL_IDX, 1, 16'h0000);
    i_mem(OP_ROR_IDX, 1, 16'h0000);
    i_mem(OP_ROL_IDX, 2, 16'h0000);
    i_mem(OP_ROR_IDX, 2, 16'h0000);
    rec <= 1'b1;
    axi_wr(REG_CTRL, 32'h1);
    while (tr.size() < eq.size() + 20) @(posedge aclk);
    axi_wr(REG_CTRL, 32'h0);
    d = '0;
    while (d[0] !== 1'b1) axi_rd(REG_STATUS);
    k = 0;
    while (k + 1 < tr.size() && tr[k + 1] === eq[0]) k++;
    for (i = 0; i < eq.size(); i++) begin
      cmp_cyc(tr[k + i], eq[i]);
    end
    chk(REG_SP, sp, RESP_OKAY);
    chk(REG_X, xr, RESP_OKAY);
    chk(REG_Y, yr, RESP_OKAY);
    chk(REG_AB, {rb, ra}, RESP_OKAY);
    chk(REG_FLAGS, {8'h00, fl}, RESP_OKAY);
    wrap_up();
  end
endmodule
